// ### logic/switch_global_control_regs.sv
// Switch global control registers with storm limiter and null VID substitution
// Overview of operation
// RULE1: Flow control bit 5 enables full-duplex pause on the host port link.
// RULE2: Flow control bit resets to the sampled flow control strap pin.
// RULE3: Speed bit 4 selects 10 Mbps when set, 100 Mbps when clear.
// RULE4: Speed bit resets to the sampled speed strap pin.
// RULE5: Bit 3 set replaces a null VID with the port default VID.
// RULE6: Threshold is 11 bits: upper three in host register, lower eight next.
// RULE7: Threshold counts 64-byte blocks allowed per input port per period.
// RULE8: Period is 50 ms at 100 Mbps and 500 ms at 10 Mbps.
// RULE9: Threshold resets to 0x04A, about one percent of bandwidth.
// RULE10: Bit 7 picks falling (1) or rising (0) sampling edge for port 3.
// RULE11: Bit 6 picks falling (1) or rising (0) sampling edge for port 4.
// RULE12: Port exceeding threshold drops broadcast data until next period.
//
// Local design decision: the Avalon-MM register port.
`timescale 1ns/1ns
module switch_global_control_regs #(
   parameter int unsigned NUM_PORTS = 4,
   parameter int unsigned TICK_CYC = swc_pkg::TICK_CYC
) (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic [5:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] writedata,
   input wire logic [3:0] byteenable,
   output logic [31:0] readdata,
   output logic waitrequest,
   input wire logic flow_ctl_strap_pin,
   input wire logic speed_strap_pin,
   input wire logic [NUM_PORTS-1:0] port_10m,
   input wire logic [NUM_PORTS-1:0] bcast_block,
   input wire logic [11:0] vid_in,
   input wire logic [11:0] pvid_in,
   output logic [11:0] vid_out,
   output logic [NUM_PORTS-1:0] storm_drop,
   output swc_pkg::host_cfg_s cfg
);
   localparam int unsigned TW = $clog2(TICK_CYC);
   localparam int unsigned SW = $clog2(swc_pkg::SLOW_TICKS);

   // ******************************
   // State
   // ******************************
   typedef struct packed {
      logic [1:0] fc_sync;
      logic [1:0] spd_sync;
      logic flow;
      logic spd;
      logic nvid;
      logic [2:0] thr_hi;
      logic [7:0] thr_lo;
      logic e3;
      logic e4;
      logic ack;
      logic [31:0] rdata;
      logic [TW-1:0] tick_cnt;
      logic [SW-1:0] slow_cnt;
      logic [NUM_PORTS-1:0][10:0] blk_cnt;
      logic [NUM_PORTS-1:0] drop;
      logic [11:0] vid;
   } state_s;

   state_s state_reg;
   state_s state_next;
   state_s init;
   logic tick;
   logic slow_wrap;
   logic take;
   logic [10:0] thr;
   logic [NUM_PORTS-1:0] period_end;
   logic [NUM_PORTS-1:0] is_10m;

   // Word select from a byte address, low two bits ignored
   function automatic logic hit(input logic [5:0] a, input logic [7:0] idx);
      return a[5:2] == idx[3:0];
   endfunction

   // ******************************
   // Bus handshake
   // ******************************
   // One wait state per access; readdata is loaded on the waiting cycle
   assign waitrequest = (read | write) & ~state_reg.ack;
   assign take = (read | write) & state_reg.ack;
   assign readdata = state_reg.rdata;
   assign thr = {state_reg.thr_hi, state_reg.thr_lo}; // RULE6

   // Base tick every 50 ms; slow ports see every tenth tick
   assign tick = state_reg.tick_cnt == TW'(TICK_CYC - 1); // RULE8
   assign slow_wrap = state_reg.slow_cnt == SW'(swc_pkg::SLOW_TICKS - 1); // RULE8

   // Host port speed comes from the register, others from the core
   always_comb begin
      is_10m = port_10m;
      is_10m[NUM_PORTS-1] = state_reg.spd; // RULE3
   end

   // Period boundary per port
   genvar p;
   generate
      for (p = 0; p < NUM_PORTS; p++) begin : g_period
         assign period_end[p] = tick & (~is_10m[p] | slow_wrap); // RULE8
      end
   endgenerate

   // ******************************
   // Reset image
   // ******************************
   // Synchronisers keep running under reset so straps are caught at release
   always_comb begin
      init = '0;
      init.fc_sync = {state_reg.fc_sync[0], flow_ctl_strap_pin};
      init.spd_sync = {state_reg.spd_sync[0], speed_strap_pin};
      init.flow = state_reg.fc_sync[1]; // RULE2
      init.spd = state_reg.spd_sync[1]; // RULE4
      init.thr_hi = swc_pkg::STORM_HIGH_RST; // RULE9
      init.thr_lo = swc_pkg::STORM_LOW_RST; // RULE9
   end

   // ******************************
   // Next state
   // ******************************
   always_comb begin
      state_next = state_reg;
      state_next.fc_sync = {state_reg.fc_sync[0], flow_ctl_strap_pin};
      state_next.spd_sync = {state_reg.spd_sync[0], speed_strap_pin};
      state_next.ack = (read | write) & ~state_reg.ack;
      // Read data prepared while waitrequest is high
      if (read & ~state_reg.ack) begin
         state_next.rdata = '0;
         if (hit(address, swc_pkg::IDX_HOST)) begin
            state_next.rdata[swc_pkg::FC_BIT] = state_reg.flow;
            state_next.rdata[swc_pkg::SPD_BIT] = state_reg.spd;
            state_next.rdata[swc_pkg::NVID_BIT] = state_reg.nvid;
            state_next.rdata[2:0] = state_reg.thr_hi;
         end else if (hit(address, swc_pkg::IDX_STORM_LOW)) begin
            state_next.rdata[7:0] = state_reg.thr_lo;
         end else if (hit(address, swc_pkg::IDX_TEST_A)) begin
            state_next.rdata[7:0] = swc_pkg::TEST_A_VAL;
         end else if (hit(address, swc_pkg::IDX_TEST_B)) begin
            state_next.rdata[7:0] = swc_pkg::TEST_B_VAL;
         end else if (hit(address, swc_pkg::IDX_TEST_C)) begin
            state_next.rdata[7:0] = swc_pkg::TEST_C_VAL;
         end else if (hit(address, swc_pkg::IDX_EDGE)) begin
            state_next.rdata[swc_pkg::EDGE3_BIT] = state_reg.e3;
            state_next.rdata[swc_pkg::EDGE4_BIT] = state_reg.e4;
         end
      end
      // Writes land on the accepting edge; test registers ignore them
      if (write & take & byteenable[0]) begin
         if (hit(address, swc_pkg::IDX_HOST)) begin
            state_next.flow = writedata[swc_pkg::FC_BIT]; // RULE1
            state_next.spd = writedata[swc_pkg::SPD_BIT]; // RULE3
            state_next.nvid = writedata[swc_pkg::NVID_BIT]; // RULE5
            state_next.thr_hi = writedata[2:0]; // RULE6
         end else if (hit(address, swc_pkg::IDX_STORM_LOW)) begin
            state_next.thr_lo = writedata[7:0]; // RULE6
         end else if (hit(address, swc_pkg::IDX_EDGE)) begin
            state_next.e3 = writedata[swc_pkg::EDGE3_BIT]; // RULE10
            state_next.e4 = writedata[swc_pkg::EDGE4_BIT]; // RULE11
         end
      end
      // Period timebase
      if (tick) begin
         state_next.tick_cnt = '0;
         state_next.slow_cnt = slow_wrap ? '0 : SW'(state_reg.slow_cnt + 1'b1);
      end else begin
         state_next.tick_cnt = TW'(state_reg.tick_cnt + 1'b1);
      end
      // Block counters saturate so a long storm cannot wrap back under
      for (int i = 0; i < NUM_PORTS; i++) begin
         if (period_end[i]) begin
            state_next.blk_cnt[i] = {10'h000, bcast_block[i]}; // RULE7
         end else if (bcast_block[i] && state_reg.blk_cnt[i] != 11'h7FF) begin
            state_next.blk_cnt[i] = 11'(state_reg.blk_cnt[i] + 1'b1); // RULE7
         end
         // Compare with the threshold as it will stand, so a write and a count agree
         state_next.drop[i] = state_next.blk_cnt[i] >
            {state_next.thr_hi, state_next.thr_lo}; // RULE12
      end
      // Null VID substitution on the ingress tag
      if (state_reg.nvid && vid_in == 12'h000) begin
         state_next.vid = pvid_in; // RULE5
      end else begin
         state_next.vid = vid_in;
      end
   end

   // Register the whole state
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         state_reg <= init;
      end else begin
         state_reg <= state_next;
      end
   end

   // ******************************
   // Outputs
   // ******************************
   assign vid_out = state_reg.vid;
   assign storm_drop = state_reg.drop; // RULE12
   assign cfg.flow_ctl_en = state_reg.flow; // RULE1
   assign cfg.speed_10m = state_reg.spd; // RULE3
   assign cfg.null_vid_en = state_reg.nvid;
   assign cfg.edge3_fall = state_reg.e3; // RULE10
   assign cfg.edge4_fall = state_reg.e4; // RULE11
   assign cfg.storm_thr = thr;

   // ******************************
   // Checks
   // ******************************
   a_wait_first: assert property (@(posedge sys_clk) disable iff (!rst_n) // Local design decision
      (read | write) && !state_reg.ack |-> waitrequest ##1 !waitrequest)
      else $error("access not answered after one wait state");

   a_flow_write: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE1
      write && !waitrequest && byteenable[0] && hit(address, swc_pkg::IDX_HOST)
      |=> cfg.flow_ctl_en == $past(writedata[swc_pkg::FC_BIT]))
      else $error("flow control bit did not follow write");

   a_strap_load: assert property (@(posedge sys_clk) // RULE2
      $rose(rst_n) |-> cfg.flow_ctl_en == $past(state_reg.fc_sync[1])
      && cfg.speed_10m == $past(state_reg.spd_sync[1]))
      else $error("strap value not loaded at reset");

   a_speed_write: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE3
      write && !waitrequest && byteenable[0] && hit(address, swc_pkg::IDX_HOST)
      |=> cfg.speed_10m == $past(writedata[swc_pkg::SPD_BIT]))
      else $error("speed bit did not follow write");

   a_vid_subst: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE5
      cfg.null_vid_en && vid_in == 12'h000 |=> vid_out == $past(pvid_in))
      else $error("null VID not replaced");

   a_thr_reset: assert property (@(posedge sys_clk) // RULE9
      $rose(rst_n) |-> cfg.storm_thr == {swc_pkg::STORM_HIGH_RST, swc_pkg::STORM_LOW_RST})
      else $error("threshold reset value wrong");

   a_edge_write: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE10
      write && !waitrequest && byteenable[0] && hit(address, swc_pkg::IDX_EDGE)
      |=> cfg.edge3_fall == $past(writedata[7]) && cfg.edge4_fall == $past(writedata[6]))
      else $error("edge select did not follow write");

   a_drop_cause: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE12
      storm_drop[0] |-> state_reg.blk_cnt[0] > thr)
      else $error("drop without exceeding threshold");

   a_period_clear: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE8
      period_end[0] && !bcast_block[0] |=> state_reg.blk_cnt[0] == 11'h000 && !storm_drop[0])
      else $error("period end did not clear count");

   a_high_write: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE6
      write && !waitrequest && byteenable[0] && hit(address, swc_pkg::IDX_HOST)
      |=> cfg.storm_thr[10:8] == $past(writedata[2:0]))
      else $error("threshold upper bits did not follow write");

   a_low_write: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE6
      write && !waitrequest && byteenable[0] && hit(address, swc_pkg::IDX_STORM_LOW)
      |=> cfg.storm_thr[7:0] == $past(writedata[7:0]))
      else $error("threshold low byte did not follow write");

   a_low_read: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE6
      read && !waitrequest && hit(address, swc_pkg::IDX_STORM_LOW)
      |-> readdata == {24'h00_0000, cfg.storm_thr[7:0]})
      else $error("threshold low byte read back wrong");

   a_nvid_write: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE5
      write && !waitrequest && byteenable[0] && hit(address, swc_pkg::IDX_HOST)
      |=> cfg.null_vid_en == $past(writedata[swc_pkg::NVID_BIT]))
      else $error("null VID enable did not follow write");

   a_block_count: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE7
      bcast_block[0] && !period_end[0] && state_reg.blk_cnt[0] != 11'h7FF
      |=> state_reg.blk_cnt[0] == 11'($past(state_reg.blk_cnt[0]) + 11'h001))
      else $error("broadcast block not counted");

   a_drop_rise: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE12
      bcast_block[0] && !period_end[0] && !write && state_reg.blk_cnt[0] == thr
      && thr != 11'h7FF |=> storm_drop[0])
      else $error("drop not raised past threshold");

   a_drop_hold: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE12
      storm_drop[0] && !period_end[0] && !write |=> storm_drop[0])
      else $error("drop released before period end");

   a_vid_pass: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE5
      !(cfg.null_vid_en && vid_in == 12'h000) |=> vid_out == $past(vid_in))
      else $error("VID altered without substitution");

   a_edge_reset: assert property (@(posedge sys_clk) // RULE11
      $rose(rst_n) |-> !cfg.edge3_fall && !cfg.edge4_fall)
      else $error("edge select not cleared by reset");

   a_flow_hold: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE1
      !(write && !waitrequest) |=> $stable(cfg.flow_ctl_en))
      else $error("flow control bit changed without a write");

   a_speed_fast: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE3
      tick && !cfg.speed_10m |-> period_end[NUM_PORTS-1])
      else $error("host port at 100 Mbps missed its period");

   a_speed_slow: assert property (@(posedge sys_clk) disable iff (!rst_n) // RULE3
      tick && cfg.speed_10m && !slow_wrap |-> !period_end[NUM_PORTS-1])
      else $error("host port at 10 Mbps ended its period early");

endmodule // switch_global_control_regs

// ### logic/swc_pkg.sv
// Shared constants and types for the switch global control register bank
package swc_pkg;
   // ******************************
   // Clock and storm timing
   // ******************************
   localparam int unsigned CLK_HZ = 125_000_000;
   localparam int unsigned PERIOD_FAST_MS = 50;   // Port at 100 Mbps
   localparam int unsigned PERIOD_SLOW_MS = 500;  // Port at 10 Mbps
   localparam int unsigned TICK_CYC = (CLK_HZ / 1000) * PERIOD_FAST_MS;
   localparam int unsigned SLOW_TICKS = PERIOD_SLOW_MS / PERIOD_FAST_MS;
   localparam int unsigned BLOCK_BYTES = 64;      // Granule of the storm count
   // ******************************
   // Register indices, byte address is four times the index
   // ******************************
   localparam logic [7:0] IDX_HOST = 8'h06;
   localparam logic [7:0] IDX_STORM_LOW = 8'h07;
   localparam logic [7:0] IDX_TEST_A = 8'h08;
   localparam logic [7:0] IDX_TEST_B = 8'h09;
   localparam logic [7:0] IDX_TEST_C = 8'h0A;
   localparam logic [7:0] IDX_EDGE = 8'h0B;
   // ******************************
   // Field positions
   // ******************************
   localparam int unsigned FC_BIT = 5;
   localparam int unsigned SPD_BIT = 4;
   localparam int unsigned NVID_BIT = 3;
   localparam int unsigned EDGE3_BIT = 7;
   localparam int unsigned EDGE4_BIT = 6;
   // ******************************
   // Values after reset
   // ******************************
   localparam logic [7:0] STORM_LOW_RST = 8'h4A;
   localparam logic [2:0] STORM_HIGH_RST = 3'h0;
   localparam logic [7:0] TEST_A_VAL = 8'h00;
   localparam logic [7:0] TEST_B_VAL = 8'h4C;
   localparam logic [7:0] TEST_C_VAL = 8'h00;
   // ******************************
   // Configuration carried to the switch core
   // ******************************
   typedef struct packed {
      logic flow_ctl_en;   // Full-duplex pause on host_port_link
      logic speed_10m;     // 1: 10 Mbps, 0: 100 Mbps
      logic null_vid_en;   // Replace null VID with port VID
      logic edge3_fall;    // third_port_rmii_link samples on falling edge
      logic edge4_fall;    // host_port_link samples on falling edge
      logic [10:0] storm_thr;
   } host_cfg_s;
endpackage

// ### test/switch_global_control_regs_tb.sv
// Self-checking bench for the switch global control register bank
`timescale 1ns/1ns
`define CHK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin fails++; \
$display("unexpected %s expected %h seen %h", nm, ex, got); end end
module switch_global_control_regs_tb;
   // Short base period keeps the storm windows brief
   localparam int unsigned TICKS = 20;
   typedef struct packed {
      logic [5:0] a;
      logic [7:0] w;
      logic [3:0] be;
      logic [7:0] pre;
      logic [7:0] post;
   } row_s;
   logic sys_clk = 1'b0;
   logic rst_n = 1'b0;
   logic [5:0] address = 6'h00;
   logic read = 1'b0;
   logic write = 1'b0;
   logic [31:0] writedata = 32'h0000_0000;
   logic [3:0] byteenable = 4'h0;
   logic [31:0] readdata;
   logic waitrequest;
   logic flow_ctl_strap_pin = 1'b1;
   logic speed_strap_pin = 1'b1;
   logic [3:0] port_10m = 4'h2;
   logic [3:0] bcast_block = 4'h0;
   logic [11:0] vid_in = 12'h000;
   logic [11:0] pvid_in = 12'h000;
   logic [11:0] vid_out;
   logic [3:0] storm_drop;
   swc_pkg::host_cfg_s cfg;
   logic [31:0] q;
   int fails = 0;
   int cmp_count = 0;
   // ******************************
   // Register rows: address, write data, lanes, value before, value after
   // ******************************
   row_s rows [8] = '{
      '{6'h18, 8'hFF, 4'h1, 8'h30, 8'h3F}, '{6'h1C, 8'h03, 4'h1, 8'h4A, 8'h03},
      '{6'h20, 8'hFF, 4'h1, 8'h00, 8'h00}, '{6'h24, 8'hFF, 4'h1, 8'h4C, 8'h4C},
      '{6'h28, 8'hFF, 4'h1, 8'h00, 8'h00}, '{6'h2C, 8'hFF, 4'h1, 8'h00, 8'hC0},
      '{6'h00, 8'hFF, 4'h1, 8'h00, 8'h00}, '{6'h2C, 8'h00, 4'h0, 8'hC0, 8'hC0}};
   always #4 sys_clk = ~sys_clk;
   switch_global_control_regs #(.NUM_PORTS(4), .TICK_CYC(TICKS)) DUT (
      .sys_clk(sys_clk), .rst_n(rst_n), .address(address), .read(read), .write(write),
      .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
      .waitrequest(waitrequest), .flow_ctl_strap_pin(flow_ctl_strap_pin),
      .speed_strap_pin(speed_strap_pin), .port_10m(port_10m), .bcast_block(bcast_block),
      .vid_in(vid_in), .pvid_in(pvid_in), .vid_out(vid_out), .storm_drop(storm_drop),
      .cfg(cfg));
   // ******************************
   // Bus access and closing
   // ******************************
   // Held until waitrequest is sampled low on a rising edge; a hang is left to the watchdog
   task xfer(input logic wr, input logic [5:0] a, input logic [7:0] d, input logic [3:0] be);
      address <= a;
      writedata <= {24'h00_0000, d};
      byteenable <= be;
      write <= wr;
      read <= ~wr;
      @(posedge sys_clk);
      while (waitrequest !== 1'b0) @(posedge sys_clk);
      q = readdata;
      read <= 1'b0;
      write <= 1'b0;
      @(posedge sys_clk);
   endtask
   task conclude;
      $display("comparisons %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   // Align to a period edge, then count up to and past the threshold of 3
   task storm(input int p, input int lo, input int hi);
      int k;
      k = 0;
      bcast_block[p] <= 1'b1;
      while (storm_drop[p] !== 1'b1) begin @(negedge sys_clk); k++; end
      @(posedge sys_clk);
      bcast_block[p] <= 1'b0;
      k = 0;
      while (storm_drop[p] !== 1'b0) begin @(negedge sys_clk); k++; end
      @(posedge sys_clk);
      repeat (3) begin
         bcast_block[p] <= 1'b1;
         @(posedge sys_clk);
         bcast_block[p] <= 1'b0;
         @(posedge sys_clk);
      end
      @(negedge sys_clk);
      `CHK("drop at threshold", 1'b0, storm_drop[p])
      @(posedge sys_clk);
      bcast_block[p] <= 1'b1;
      @(posedge sys_clk);
      bcast_block[p] <= 1'b0;
      @(posedge sys_clk);
      @(negedge sys_clk);
      `CHK("drop over threshold", 1'b1, storm_drop[p])
      k = 0;
      while (storm_drop[p] !== 1'b0 && k < 400) begin @(negedge sys_clk); k++; end
      `CHK("drop span", 1'b1, (k >= lo && k <= hi))
      @(posedge sys_clk);
   endtask
   // Watchdog well beyond the thousand or so cycles of the run
   initial begin
      #160000;
      fails++;
      conclude();
   end
   // ******************************
   // Main sequence
   // ******************************
   initial begin
      repeat (8) @(posedge sys_clk);
      rst_n <= 1'b1;
      @(posedge sys_clk);
      `CHK("flow strap", 1'b1, cfg.flow_ctl_en)
      `CHK("speed strap", 1'b1, cfg.speed_10m)
      `CHK("threshold reset", 11'h04A, cfg.storm_thr)
      foreach (rows[i]) begin
         xfer(1'b0, rows[i].a, 8'h00, 4'h0);
         `CHK("read before", {24'h00_0000, rows[i].pre}, q)
         xfer(1'b1, rows[i].a, rows[i].w, rows[i].be);
         xfer(1'b0, rows[i].a, 8'h00, 4'h0);
         `CHK("read after", {24'h00_0000, rows[i].post}, q)
      end
      `CHK("cfg flags", 5'h1F, cfg[15:11])
      `CHK("threshold joined", 11'h703, cfg.storm_thr)
      // Null VID is swapped only while substitution is on
      vid_in <= 12'h000;
      pvid_in <= 12'h123;
      @(posedge sys_clk);
      @(negedge sys_clk);
      `CHK("null vid swapped", 12'h123, vid_out)
      @(posedge sys_clk);
      vid_in <= 12'h055;
      @(posedge sys_clk);
      @(negedge sys_clk);
      `CHK("vid passed", 12'h055, vid_out)
      @(posedge sys_clk);
      vid_in <= 12'h000;
      xfer(1'b1, 6'h18, 8'h00, 4'h1);
      // The output register needs the edge after the write to drop the swap
      @(negedge sys_clk);
      `CHK("null vid kept", 12'h000, vid_out)
      `CHK("flow and speed off", 2'h0, {cfg.flow_ctl_en, cfg.speed_10m})
      @(posedge sys_clk);
      storm(0, 5, 20);
      storm(1, 150, 200);
      // Host port period follows its own speed bit
      xfer(1'b1, 6'h18, 8'h10, 4'h1);
      storm(3, 150, 200);
      // Second reset with the flow control strap turned the other way, speed strap left set
      flow_ctl_strap_pin <= 1'b0;
      speed_strap_pin <= 1'b1;
      rst_n <= 1'b0;
      repeat (8) @(posedge sys_clk);
      rst_n <= 1'b1;
      @(posedge sys_clk);
      `CHK("flags after reset", 5'h08, cfg[15:11])
      `CHK("threshold after reset", 11'h04A, cfg.storm_thr)
      `CHK("drop after reset", 4'h0, storm_drop)
      conclude();
   end
endmodule // switch_global_control_regs_tb
